// >>> core/sfph_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) With chip select high and no self-timed operation busy, the device rests in standby.
// (R2) In deep sleep every command is ignored except the wake command.
// (R3) Opcode B9h then chip select release enters deep sleep within the entry delay.
// (R4) A partial sleep opcode or a release off a byte boundary cancels entry and keeps standby.
// (R5) After power-up the device is in standby, never in deep sleep.
// (R6) A sleep command while a program or erase runs is discarded and must be reissued.
// (R7) Opcode ABh then chip select release returns to standby within the wake delay.
// (R8) A partial wake opcode or a release off a byte boundary leaves the device asleep.
// (R9) Pause never stalls a running program or erase cycle.
// (R10) Pause starts with chip select low and hold active in an SCK low phase and lasts while both stay.
// (R11) Hold going active in an SCK high phase starts the pause at the next low phase.
// (R12) While paused the output floats, SI and SCK are ignored, and write-protect still acts.
// (R13) Pause ends on hold release in a low phase, or at the next low phase if released high.
// (R14) Chip select release with hold active aborts the operation and clears the write-enable latch.
// (R15) Output data launch on SCK falling edges and input data are sampled on rising edges.
// (R16) The host captures on the next falling edge and launches its data on falling edges.
// (R17) Bits are counted MSB first from chip select low to find the opcode and byte alignment.
module sfph_ctrl import sfph_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic busy,
  input wire logic tx_bit,
  input wire logic tx_en,
  output logic so_o,
  output logic so_oe,
  output logic standby,
  output logic deep_sleep,
  output logic paused,
  output logic wp_active,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic op_abort,
  output logic write_enable_latch_clear
);

  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;
  logic sck_q;
  logic cs_act_q;
  logic [2:0] bit_idx;
  logic [7:0] shift;
  logic [7:0] opcode;
  logic have_op;
  logic [DELAY_W-1:0] delay_cnt;
  logic [DELAY_W-1:0] next_delay_cnt;
  sfph_pwr_t state;
  sfph_pwr_t next_state;
  logic next_paused;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sfph_sync #(.RESET_VAL(PIN_IDLE_LOW)) u_sync_sck (
    .clk_sys(clk_sys), .rst(rst), .d(sck), .q(sck_s)
  );
  sfph_sync #(.RESET_VAL(PIN_IDLE_HIGH)) u_sync_cs (
    .clk_sys(clk_sys), .rst(rst), .d(cs_n), .q(cs_n_s)
  );
  sfph_sync #(.RESET_VAL(PIN_IDLE_LOW)) u_sync_si (
    .clk_sys(clk_sys), .rst(rst), .d(si), .q(si_s)
  );
  sfph_sync #(.RESET_VAL(PIN_IDLE_HIGH)) u_sync_hold (
    .clk_sys(clk_sys), .rst(rst), .d(hold_n), .q(hold_n_s)
  );
  sfph_sync #(.RESET_VAL(PIN_IDLE_HIGH)) u_sync_wp (
    .clk_sys(clk_sys), .rst(rst), .d(wp_n), .q(wp_n_s)
  );

  wire cs_act = ~cs_n_s;
  wire hold_act = ~hold_n_s;
  wire sck_rise = sck_s & ~sck_q;
  wire sck_fall = ~sck_s & sck_q;
  wire cs_release = ~cs_act & cs_act_q;
  wire aligned = (bit_idx == BIT_IDX_ZERO);
  // (R12) sck ignored while paused
  wire bit_take = cs_act & sck_rise & ~paused;
  wire byte_done = bit_take & (bit_idx == BIT_IDX_LAST);
  wire [7:0] byte_in = {shift[6:0], si_s};
  // (R14) release under hold aborts, so no command acts on it
  wire release_ok = cs_release & ~hold_act & aligned & have_op;
  // (R3) sleep taken on clean release; (R4) partial or misaligned falls through
  // (R6) refused while a self-timed cycle runs
  wire sleep_go = release_ok & (state == PWR_STANDBY) & (opcode == OP_SLEEP) & ~busy;
  // (R7) wake taken on clean release; (R8) anything else stays in sleep
  wire wake_go = release_ok & (state == PWR_SLEEP) & (opcode == OP_WAKE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_q <= 1'b0;
      cs_act_q <= 1'b0;
    end else begin
      sck_q <= sck_s;
      cs_act_q <= cs_act;
    end
  end

  // (R17) msb-first bit counter from select low
  always_ff @(posedge clk_sys) begin
    if (rst || !cs_act) begin
      bit_idx <= BIT_IDX_ZERO;
      shift <= 8'h00;
      have_op <= 1'b0;
    end else if (bit_take) begin
      bit_idx <= bit_idx + 3'h1;
      shift <= byte_in;
      if (byte_done) begin
        have_op <= 1'b1;
      end
    end
  end

  // (R3) only the first byte is the opcode, the rest is ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opcode <= 8'h00;
    end else if (byte_done && !have_op) begin
      opcode <= byte_in;
    end
  end

  // (R2) no byte reaches the command logic unless in standby
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= byte_done & (state == PWR_STANDBY);
      if (byte_done) begin
        rx_byte <= byte_in;
      end
    end
  end

  // power state sequencing; the settle counter stands in for the analog delay
  always_comb begin
    next_state = state;
    next_delay_cnt = delay_cnt;
    case (state)
      PWR_STANDBY: begin
        if (sleep_go) begin
          next_state = PWR_ENTERING;
          next_delay_cnt = DELAY_W'(SLEEP_ENTRY_CYC);
        end
      end
      PWR_ENTERING: begin
        if (delay_cnt <= DELAY_ONE) begin
          next_state = PWR_SLEEP;
          next_delay_cnt = DELAY_ZERO;
        end else begin
          next_delay_cnt = delay_cnt - DELAY_ONE;
        end
      end
      PWR_SLEEP: begin
        if (wake_go) begin
          next_state = PWR_WAKING;
          next_delay_cnt = DELAY_W'(WAKE_CYC);
        end
      end
      PWR_WAKING: begin
        if (delay_cnt <= DELAY_ONE) begin
          next_state = PWR_STANDBY;
          next_delay_cnt = DELAY_ZERO;
        end else begin
          next_delay_cnt = delay_cnt - DELAY_ONE;
        end
      end
      default: begin
        next_state = PWR_STANDBY;
        next_delay_cnt = DELAY_ZERO;
      end
    endcase
  end

  // (R5) reset lands in standby
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= PWR_STANDBY;
      delay_cnt <= DELAY_ZERO;
    end else begin
      state <= next_state;
      delay_cnt <= next_delay_cnt;
    end
  end

  assign deep_sleep = (state == PWR_SLEEP);

  // (R1) standby status from select, busy and power state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      standby <= 1'b1;
    end else begin
      standby <= (state == PWR_STANDBY) & ~cs_act & ~busy;
    end
  end

  // (R10) (R11) (R13) pause follows hold only in sck low phases
  assign next_paused = ~cs_act ? 1'b0 : (~sck_s ? hold_act : paused);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      paused <= 1'b0;
    end else begin
      paused <= next_paused;
    end
  end

  // (R14) abort and latch clear on release under hold
  // (R9) busy is never gated by pause; only the command is dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_abort <= 1'b0;
      write_enable_latch_clear <= 1'b0;
    end else begin
      op_abort <= cs_release & hold_act;
      write_enable_latch_clear <= cs_release & hold_act;
    end
  end

  // (R12) write-protect tracked in every mode, pause included
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_active <= 1'b0;
    end else begin
      wp_active <= ~wp_n_s;
    end
  end

  // (R15) output bit launched on falling sck, floated while paused
  // the synchroniser adds latency, so only slow sck leaves full-cycle margin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= cs_act & ~next_paused & tx_en & (state == PWR_STANDBY);
      if (sck_fall && cs_act && !paused) begin
        so_o <= tx_bit;
      end
    end
  end

  localparam int A_ENTRY_MAX = SLEEP_ENTRY_CYC + 1;
  localparam int A_WAKE_MAX = WAKE_CYC + 1;

  sequence s_sleep_req;
    sleep_go;
  endsequence

  sequence s_wake_req;
    wake_go;
  endsequence

  a_standby_idle: // (R1)
    assert property ((state == PWR_STANDBY && !cs_act && !busy) |=> standby)
    else $error("standby not shown while idle");

  a_sleep_ignore: // (R2)
    assert property (deep_sleep |=> !rx_valid)
    else $error("byte passed in deep sleep");

  a_sleep_entry: // (R3)
    assert property (s_sleep_req |-> ##[1:A_ENTRY_MAX] deep_sleep)
    else $error("sleep not entered in time");

  a_sleep_cancel: // (R4)
    assert property ((cs_release && state == PWR_STANDBY && !aligned) |=> state == PWR_STANDBY)
    else $error("misaligned sleep accepted");

  a_reset_standby: // (R5)
    assert property ($fell(rst) |-> state == PWR_STANDBY && !deep_sleep)
    else $error("not standby after reset");

  a_busy_discard: // (R6)
    assert property ((cs_release && busy && state == PWR_STANDBY) |=> state == PWR_STANDBY)
    else $error("sleep taken while busy");

  a_wake_exit: // (R7)
    assert property (s_wake_req |-> ##[1:A_WAKE_MAX] state == PWR_STANDBY)
    else $error("wake not done in time");

  a_wake_cancel: // (R8)
    assert property ((cs_release && deep_sleep && !wake_go) |=> deep_sleep)
    else $error("left sleep without clean wake");

  a_pause_enter: // (R10)
    assert property ((cs_act && !sck_s && hold_act) |=> paused)
    else $error("pause not entered in low phase");

  a_pause_high_hold: // (R11)
    assert property ((cs_act && sck_s) |=> paused == $past(paused))
    else $error("pause changed in high phase");

  a_pause_float: // (R12)
    assert property (paused |-> !so_oe && !bit_take)
    else $error("drive or sample while paused");

  a_pause_leave: // (R13)
    assert property ((cs_act && !sck_s && !hold_act) |=> !paused)
    else $error("pause not ended in low phase");

  a_hold_abort: // (R14)
    assert property ((cs_release && hold_act) |=> op_abort && write_enable_latch_clear)
    else $error("no abort on release under hold");

  a_launch_fall: // (R15)
    assert property ($changed(so_o) |-> $past(sck_fall))
    else $error("output moved off a falling edge");

endmodule

`default_nettype wire

// >>> core/sfph_pkg.sv
package sfph_pkg;

  // system clock period
  localparam int CLK_PERIOD_NS = 20;

  // single-byte power commands
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;

  // command framing
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_IDX_LAST = 3'h7;
  localparam logic [2:0] BIT_IDX_ZERO = 3'h0;

  // longest settle times; plain defaults, nothing fixes them
  localparam int SLEEP_ENTRY_DELAY_NS = 1000;
  localparam int WAKE_DELAY_NS = 1000;

  // longest times round down, never below one cycle
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS > 0) ? SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS : 1;
  localparam int WAKE_CYC =
    (WAKE_DELAY_NS / CLK_PERIOD_NS > 0) ? WAKE_DELAY_NS / CLK_PERIOD_NS : 1;

  localparam int DELAY_W = 16;
  localparam logic [DELAY_W-1:0] DELAY_ONE = 16'h0001;
  localparam logic [DELAY_W-1:0] DELAY_ZERO = 16'h0000;

  // reset levels of the pin samplers: selects and hold idle high
  localparam logic PIN_IDLE_HIGH = 1'b1;
  localparam logic PIN_IDLE_LOW = 1'b0;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_WAKING = 2'b11
  } sfph_pwr_t;

endpackage

// >>> core/sfph_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sfph_sync import sfph_pkg::*; #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> test/sfph_host.sv
`timescale 1ns/1ps
`default_nettype none

module sfph_host (
  input wire logic so_line,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n
);
  logic last_cap;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    last_cap = 1'b0;
  end

  task automatic frame(input logic [15:0] data, input int nbits);
    cs_n = 1'b0;
    #100;
    for (int i = nbits - 1; i >= 0; i--) begin
      si = data[i];
      #80 sck = 1'b1;
      // capture on the next falling edge
      #80 last_cap = so_line;
      sck = 1'b0;
    end
    // no stale bit left on the line after the frame
    #40 si = ~si;
    #60 cs_n = 1'b1;
    #200;
  endtask

  // 200 ns covers the pin synchronisers with margin
  task automatic pins(input logic c, input logic k, input logic h);
    cs_n = c;
    sck = k;
    hold_n = h;
    #200;
  endtask
endmodule

`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import sfph_pkg::*;
  logic clk_sys, rst, wp_n, busy, tx_bit, tx_en, so_last;
  wire logic sck, cs_n, si, hold_n, so_line;
  logic so_o, so_oe, standby, deep_sleep, paused, wp_active, rx_valid, op_abort, wel_clr;
  logic [7:0] rx_byte;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_rx = 0;
  int n_abort = 0;
  int n_clr = 0;

  // released line shows the inverse of its last driven value
  assign so_line = so_oe ? so_o : ~so_last;

  sfph_host host (.so_line(so_line), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n));

  sfph_ctrl uut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .busy(busy), .tx_bit(tx_bit), .tx_en(tx_en),
    .so_o(so_o), .so_oe(so_oe), .standby(standby), .deep_sleep(deep_sleep),
    .paused(paused), .wp_active(wp_active), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .op_abort(op_abort), .write_enable_latch_clear(wel_clr));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (rst) so_last <= 1'b0;
    else if (so_oe === 1'b1) so_last <= so_o;
    if (rx_valid === 1'b1) n_rx++;
    if (op_abort === 1'b1) n_abort++;
    if (wel_clr === 1'b1) n_clr++;
    cyc++;
    // the run needs about 1300 cycles; the ceiling leaves wide margin
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wcyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_byte();
    int n0;
    n0 = n_rx;
    wcyc(1);
    tx_en = 1'b1;
    tx_bit = 1'b1;
    host.frame(16'h003C, 8);
    chk("rx_byte", 8'h3C, rx_byte);
    chk("rx count", 8'(n0 + 1), 8'(n_rx));
    chk("so capture", 8'h01, {7'h00, host.last_cap});
    chk("standby", 8'h01, {7'h00, standby});
    wcyc(1);
    tx_en = 1'b0;
    $display("test byte done");
  endtask

  task automatic t_refused();
    host.frame(16'h005C, 7);
    chk("short sleep", 8'h01, {6'h00, deep_sleep, standby});
    host.frame(16'h0173, 9);
    chk("odd sleep", 8'h01, {6'h00, deep_sleep, standby});
    wcyc(1);
    busy = 1'b1;
    host.frame(16'h00B9, 8);
    wcyc(1);
    busy = 1'b0;
    wcyc(60);
    chk("busy sleep", 8'h00, {7'h00, deep_sleep});
    $display("test refused done");
  endtask

  task automatic t_sleep_wake();
    int n0;
    host.frame(16'hB9FF, 16);
    wcyc(SLEEP_ENTRY_CYC + 5);
    chk("asleep", 8'h02, {6'h00, deep_sleep, standby});
    n0 = n_rx;
    host.frame(16'h0005, 8);
    chk("ignored cmd", 8'(n0), 8'(n_rx));
    host.frame(16'h0055, 7);
    host.frame(16'h0157, 9);
    wcyc(WAKE_CYC + 5);
    chk("bad wake", 8'h01, {7'h00, deep_sleep});
    host.frame(16'hAB00, 16);
    wcyc(WAKE_CYC + 5);
    chk("awake", 8'h01, {6'h00, deep_sleep, standby});
    n0 = n_rx;
    host.frame(16'h0005, 8);
    chk("cmd after wake", 8'h05, rx_byte);
    chk("count after wake", 8'(n0 + 1), 8'(n_rx));
    $display("test sleep wake done");
  endtask

  task automatic t_pause();
    int a0;
    int c0;
    wcyc(1);
    tx_en = 1'b1;
    host.pins(1'b0, 1'b1, 1'b1);
    host.pins(1'b0, 1'b1, 1'b0);
    chk("hold in high", 8'h00, {7'h00, paused});
    chk("drive before pause", 8'h01, {7'h00, so_oe});
    host.pins(1'b0, 1'b0, 1'b0);
    chk("paused float", 8'h02, {6'h00, paused, so_oe});
    wp_n = 1'b0;
    wcyc(10);
    chk("wp in pause", 8'h01, {7'h00, wp_active});
    wp_n = 1'b1;
    host.pins(1'b0, 1'b1, 1'b1);
    chk("release high", 8'h01, {7'h00, paused});
    chk("wp released", 8'h00, {7'h00, wp_active});
    host.pins(1'b0, 1'b0, 1'b1);
    chk("release low", 8'h01, {6'h00, paused, so_oe});
    host.pins(1'b0, 1'b0, 1'b0);
    a0 = n_abort;
    c0 = n_clr;
    host.pins(1'b1, 1'b0, 1'b0);
    chk("abort", 8'(a0 + 1), 8'(n_abort));
    chk("latch clear", 8'(c0 + 1), 8'(n_clr));
    host.pins(1'b1, 1'b0, 1'b1);
    wcyc(1);
    tx_en = 1'b0;
    $display("test pause done");
  endtask

  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    busy = 1'b0;
    tx_bit = 1'b0;
    tx_en = 1'b0;
    wcyc(16);
    rst = 1'b0;
    wcyc(5);
    chk("reset state", 8'h01, {6'h00, deep_sleep, standby});
    t_byte();
    t_refused();
    t_sleep_wake();
    t_pause();
    close_out();
  end
endmodule

`default_nettype wire
